/* design/dma_status_defines.svh */
`ifndef DMA_STATUS_DEFINES_SVH
`define DMA_STATUS_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CHANNEL_STATUS 16'hd228
`define OFS_IRQ_STATUS 16'hd230
`define OFS_IRQ_CLEAR 16'hd238
`define OFS_IRQ_ENABLE 16'hd240
`define OFS_DONE_ENABLE 16'hd248

// ----------------------------------------------------------------
// channel status field positions
// ----------------------------------------------------------------
`define ST_REQUEST_DELAY_COUNT_LSB 24
`define ST_REQUEST_DELAY_COUNT_MSB 29
`define ST_FIFO_BYTE_COUNT_LSB 20
`define ST_FIFO_BYTE_COUNT_MSB 23
`define ST_WPTR_LSB 18
`define ST_WPTR_MSB 19
`define ST_RPTR_LSB 16
`define ST_RPTR_MSB 17
`define ST_ERR_IRQ 11
`define ST_DONE_IRQ 10
`define ST_CHAIN_EN 9
`define ST_XFR_ACTIVE 8
`define ST_ABORT 7
`define ST_CHAIN_DONE 6
`define ST_XFR_DONE 5
`define ST_ERR_MSB 3
`define ST_ERR_LSB 0

// ----------------------------------------------------------------
// done enable register fields
// ----------------------------------------------------------------
`define DE_CHAIN_DONE 0
`define DE_XFR_DONE 1
`define DE_ERROR 2

// ----------------------------------------------------------------
// block interrupt event bits
// ----------------------------------------------------------------
`define EV_CHAIN_DONE 0
`define EV_XFR_DONE 1
`define EV_ERROR 2
`define EV_BAD_ACCESS 3

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define EV_COUNT 4
`define DE_COUNT 3
`define LOW_FLAG_COUNT 6
`define RESET_WORD 64'h0000_0000_0000_0000

`endif

/* design/dma_status_pkg.sv */
package dma_status_pkg;

    // ----------------------------------------------------------------
    // register select
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_STATUS = 3'b001,
        SEL_IRQ_STATUS = 3'b010,
        SEL_IRQ_CLEAR = 3'b011,
        SEL_IRQ_ENABLE = 3'b100,
        SEL_DONE_ENABLE = 3'b101
    } reg_sel_e;

    typedef logic [63:0] word_t;

endpackage

/* design/sticky_flags.sv */
// ----------------------------------------------------------------
// sticky flag bank, set wins over clear
// ----------------------------------------------------------------
module sticky_flags #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // events and clears
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] clear_mask,
    // state
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    always_comb begin
        flags_next = (flags_reg & ~clear_mask) | set_pulse;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

endmodule // sticky_flags

/* design/pci_dma_status_upper.sv */
`include "dma_status_defines.svh"

module pci_dma_status_upper
    import dma_status_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int ERR_W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [63:0] reg_rdata,
    // channel engine state
    input wire logic [5:0] request_delay_count,
    input wire logic [3:0] fifo_byte_count,
    input wire logic [1:0] fifo_write_pointer,
    input wire logic [1:0] fifo_read_pointer,
    input wire logic chain_enable,
    input wire logic transfer_active,
    // channel engine events
    input wire logic chain_done_event,
    input wire logic transfer_done_event,
    input wire logic [ERR_W-1:0] error_event,
    // status towards the system
    output logic error_irq_pending,
    output logic completion_irq_pending,
    output logic irq
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        case (addr)
            ADDR_W'(`OFS_CHANNEL_STATUS): sel = SEL_STATUS;
            ADDR_W'(`OFS_IRQ_STATUS): sel = SEL_IRQ_STATUS;
            ADDR_W'(`OFS_IRQ_CLEAR): sel = SEL_IRQ_CLEAR;
            ADDR_W'(`OFS_IRQ_ENABLE): sel = SEL_IRQ_ENABLE;
            ADDR_W'(`OFS_DONE_ENABLE): sel = SEL_DONE_ENABLE;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    function automatic logic [ERR_W-1:0] err_field(input word_t w);
        return w[`ST_ERR_LSB +: ERR_W];
    endfunction

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------
    reg_sel_e wr_sel;
    reg_sel_e rd_sel;
    logic wr_status;
    logic wr_irq_clear;
    logic wr_irq_enable;
    logic wr_done_enable;
    logic bad_access;

    always_comb begin
        wr_sel = decode(reg_addr);
        wr_status = reg_wr && (wr_sel == SEL_STATUS);
        wr_irq_clear = reg_wr && (wr_sel == SEL_IRQ_CLEAR);
        wr_irq_enable = reg_wr && (wr_sel == SEL_IRQ_ENABLE);
        wr_done_enable = reg_wr && (wr_sel == SEL_DONE_ENABLE);
    end

    always_comb begin
        rd_sel = decode(reg_addr);
        // unmapped address, or a read of the write-only clear word
        bad_access = ((reg_wr || reg_rd) && (rd_sel == SEL_NONE))
            || (reg_rd && (rd_sel == SEL_IRQ_CLEAR));
    end

    // ----------------------------------------------------------------
    // lower status flags: errors, chain done, transfer done
    // ----------------------------------------------------------------
    logic [`LOW_FLAG_COUNT-1:0] low_set;
    logic [`LOW_FLAG_COUNT-1:0] low_clear;
    logic [`LOW_FLAG_COUNT-1:0] low_flags;
    logic [ERR_W-1:0] err_flags;
    logic chain_done_flag;
    logic transfer_done_flag;
    logic chain_abort_flag;

    always_comb begin
        low_set = {chain_done_event, transfer_done_event, error_event};
    end

    // ----------------------------------------------------------------
    // write-one-clear decode of the status word
    // ----------------------------------------------------------------
    logic chain_done_clear;
    logic transfer_done_clear;
    logic [ERR_W-1:0] err_clear;

    always_comb begin
        chain_done_clear = 1'b0;
        transfer_done_clear = 1'b0;
        err_clear = '0;
        if (wr_status) begin
            chain_done_clear = reg_wdata[`ST_CHAIN_DONE];
            transfer_done_clear = reg_wdata[`ST_XFR_DONE];
            err_clear = err_field(reg_wdata);
        end
        low_clear = {chain_done_clear, transfer_done_clear, err_clear};
    end

    sticky_flags #(
        .WIDTH(`LOW_FLAG_COUNT)
    ) u_low_flags (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .set_pulse(low_set),
        .clear_mask(low_clear),
        .flags(low_flags)
    );

    assign err_flags = low_flags[ERR_W-1:0];
    assign transfer_done_flag = low_flags[ERR_W];
    assign chain_done_flag = low_flags[ERR_W+1];
    assign chain_abort_flag = |err_flags;

    // ----------------------------------------------------------------
    // done interrupt enables
    // ----------------------------------------------------------------
    logic [`DE_COUNT-1:0] done_enable_reg;
    logic chain_done_irq_enable;
    logic transfer_done_irq_enable;
    logic error_irq_enable;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_enable_reg <= '0;
        end else if (wr_done_enable) begin
            done_enable_reg <= reg_wdata[`DE_COUNT-1:0];
        end
    end

    assign chain_done_irq_enable = done_enable_reg[`DE_CHAIN_DONE];
    assign transfer_done_irq_enable = done_enable_reg[`DE_XFR_DONE];
    assign error_irq_enable = done_enable_reg[`DE_ERROR];

    // ----------------------------------------------------------------
    // request terms
    // ----------------------------------------------------------------
    logic err_req;
    logic done_req;

    always_comb begin
        err_req = chain_abort_flag && error_irq_enable;
    end

    always_comb begin
        done_req = (chain_done_flag && chain_done_irq_enable)
            || (transfer_done_flag && transfer_done_irq_enable);
    end

    // ----------------------------------------------------------------
    // block interrupt: sticky events, clear and enable words
    // ----------------------------------------------------------------
    logic [`EV_COUNT-1:0] ev_set;
    logic [`EV_COUNT-1:0] ev_clear;
    logic [`EV_COUNT-1:0] ev_flags;
    logic [`EV_COUNT-1:0] ev_enable_reg;

    always_comb begin
        ev_set = '0;
        ev_set[`EV_CHAIN_DONE] = chain_done_event;
        ev_set[`EV_XFR_DONE] = transfer_done_event;
        ev_set[`EV_ERROR] = |error_event;
        ev_set[`EV_BAD_ACCESS] = bad_access;
    end

    always_comb begin
        ev_clear = wr_irq_clear ? reg_wdata[`EV_COUNT-1:0] : '0;
    end

    sticky_flags #(
        .WIDTH(`EV_COUNT)
    ) u_event_flags (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .set_pulse(ev_set),
        .clear_mask(ev_clear),
        .flags(ev_flags)
    );

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ev_enable_reg <= '0;
        end else if (wr_irq_enable) begin
            ev_enable_reg <= reg_wdata[`EV_COUNT-1:0];
        end
    end

    // ----------------------------------------------------------------
    // block interrupt term
    // ----------------------------------------------------------------
    logic irq_next;

    always_comb begin
        irq_next = |(ev_flags & ev_enable_reg);
    end

    // ----------------------------------------------------------------
    // channel status word
    // ----------------------------------------------------------------
    word_t status_word;

    always_comb begin
        // reserved bits stay zero from the base word
        status_word = `RESET_WORD;
        status_word[`ST_REQUEST_DELAY_COUNT_MSB:`ST_REQUEST_DELAY_COUNT_LSB] = request_delay_count;
        status_word[`ST_FIFO_BYTE_COUNT_MSB:`ST_FIFO_BYTE_COUNT_LSB] = fifo_byte_count;
        status_word[`ST_WPTR_MSB:`ST_WPTR_LSB] = fifo_write_pointer;
        status_word[`ST_RPTR_MSB:`ST_RPTR_LSB] = fifo_read_pointer;
        status_word[`ST_ERR_IRQ] = err_req;
        status_word[`ST_DONE_IRQ] = done_req;
        status_word[`ST_CHAIN_EN] = chain_enable;
        status_word[`ST_XFR_ACTIVE] = transfer_active;
        status_word[`ST_ABORT] = chain_abort_flag;
        status_word[`ST_CHAIN_DONE] = chain_done_flag;
        status_word[`ST_XFR_DONE] = transfer_done_flag;
        status_word[`ST_ERR_LSB +: ERR_W] = err_flags;
    end

    // ----------------------------------------------------------------
    // read data, one cycle after the strobe
    // ----------------------------------------------------------------
    word_t rdata_reg;
    word_t rdata_next;

    always_comb begin
        rdata_next = `RESET_WORD;
        if (reg_rd) begin
            case (rd_sel)
                SEL_STATUS: rdata_next = status_word;
                SEL_IRQ_STATUS: rdata_next[`EV_COUNT-1:0] = ev_flags;
                SEL_IRQ_ENABLE: rdata_next[`EV_COUNT-1:0] = ev_enable_reg;
                SEL_DONE_ENABLE: rdata_next[`DE_COUNT-1:0] = done_enable_reg;
                default: rdata_next = `RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= `RESET_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic err_req_reg;
    logic done_req_reg;
    logic irq_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            err_req_reg <= 1'b0;
        end else begin
            err_req_reg <= err_req;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            done_req_reg <= 1'b0;
        end else begin
            done_req_reg <= done_req;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign error_irq_pending = err_req_reg;
    assign completion_irq_pending = done_req_reg;
    assign irq = irq_reg;

endmodule // pci_dma_status_upper

/* testbench/pci_dma_status_upper_monitor.sv */
module pci_dma_status_upper_monitor #(
    parameter int ADDR_W = 16,
    parameter int ERR_W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [63:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [63:0] reg_rdata,
    // channel engine
    input wire logic [5:0] request_delay_count,
    input wire logic [3:0] fifo_byte_count,
    input wire logic [1:0] fifo_write_pointer,
    input wire logic [1:0] fifo_read_pointer,
    input wire logic chain_enable,
    input wire logic transfer_active,
    input wire logic chain_done_event,
    input wire logic transfer_done_event,
    input wire logic [ERR_W-1:0] error_event,
    // status outputs
    input wire logic error_irq_pending,
    input wire logic completion_irq_pending,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic rd_st;
    assign rd_st = reg_rd && reg_addr == ADDR_W'(16'hd228);

    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 64'h0)
        else $error("read data not zero outside read answer");
    AST_FIELDS: assert property (rd_st |=> reg_rdata[29:16] ==
        $past({request_delay_count, fifo_byte_count, fifo_write_pointer, fifo_read_pointer}))
        else $error("diagnostic fields differ from inputs");
    AST_RESERVED: assert property (rd_st |=> reg_rdata[63:30] == 34'h0
        && reg_rdata[15:12] == 4'h0 && !reg_rdata[4])
        else $error("reserved status bits not zero");
    AST_CHAIN_MIRROR: assert property (rd_st |=> reg_rdata[9] == $past(chain_enable))
        else $error("chain enable mirror wrong");
    AST_DONE_REQ: assert property (rd_st |=> reg_rdata[10] == completion_irq_pending
        && (!reg_rdata[10] || reg_rdata[6] || reg_rdata[5]))
        else $error("completion request inconsistent");
    AST_ERR_REQ: assert property (rd_st |=> reg_rdata[11] == error_irq_pending
        && (!reg_rdata[11] || reg_rdata[7]))
        else $error("error request inconsistent");
    AST_ABORT_OR: assert property (rd_st |=> reg_rdata[7] == |reg_rdata[3:0])
        else $error("abort bit not or of error flags");
    AST_CHAIN_SET: assert property (chain_done_event ##1 !(reg_wr && reg_wdata[6]) ##1 rd_st |=> reg_rdata[6])
        else $error("chain done flag not set by event");
endmodule // pci_dma_status_upper_monitor

bind pci_dma_status_upper pci_dma_status_upper_monitor #(.ADDR_W(ADDR_W), .ERR_W(ERR_W)) u_mon (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .request_delay_count(request_delay_count), .fifo_byte_count(fifo_byte_count),
    .fifo_write_pointer(fifo_write_pointer), .fifo_read_pointer(fifo_read_pointer),
    .chain_enable(chain_enable), .transfer_active(transfer_active),
    .chain_done_event(chain_done_event), .transfer_done_event(transfer_done_event),
    .error_event(error_event), .error_irq_pending(error_irq_pending),
    .completion_irq_pending(completion_irq_pending), .irq(irq));

/* testbench/pci_dma_status_upper_tb.sv */
module pci_dma_status_upper_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0;
    logic [63:0] reg_wdata = 64'h0;
    logic [63:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] dly = 6'h0;
    logic [3:0] cnt = 4'h0;
    logic [3:0] err_ev = 4'h0;
    logic [1:0] wp = 2'h0;
    logic [1:0] rp = 2'h0;
    logic ch_en = 1'b0;
    logic act = 1'b0;
    logic cd_ev = 1'b0;
    logic td_ev = 1'b0;
    logic err_req, done_req, irq;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    pci_dma_status_upper dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .request_delay_count(dly),
        .fifo_byte_count(cnt), .fifo_write_pointer(wp), .fifo_read_pointer(rp),
        .chain_enable(ch_en), .transfer_active(act), .chain_done_event(cd_ev),
        .transfer_done_event(td_ev), .error_event(err_ev), .error_irq_pending(err_req),
        .completion_irq_pending(done_req), .irq(irq));

    always #2 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            end_sim;
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [63:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rs(input logic [15:0] a, input logic [63:0] x);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, x);
    endtask

    task automatic ev(input logic c, input logic t, input logic [3:0] e);
        @(posedge clk_sys);
        cd_ev <= c;
        td_ev <= t;
        err_ev <= e;
        @(posedge clk_sys);
        cd_ev <= 1'b0;
        td_ev <= 1'b0;
        err_ev <= 4'h0;
    endtask

    function automatic logic [63:0] st(input logic e11, input logic e10, input logic cd,
                                       input logic td, input logic [3:0] ef);
        return {34'h0, dly, cnt, wp, rp, 4'h0, e11, e10, ch_en, act, |ef, cd, td, 1'b0, ef};
    endfunction

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rs(16'hd228, 64'h0);
        rs(16'hd230, 64'h0);
        rs(16'hd248, 64'h0);
        chk(64'({err_req, done_req, irq}), 64'h0);
        $display("t_reset done");
    endtask

    task automatic t_fields;
        @(posedge clk_sys);
        {dly, cnt, wp, rp, ch_en, act} <= {6'h3f, 4'h9, 2'h2, 2'h1, 2'b11};
        #1;
        rs(16'hd228, st(0, 0, 0, 0, 4'h0));
        wr(16'hd228, 64'hffff_ffff_ffff_ffff);
        {dly, cnt, wp, rp, ch_en, act} <= {6'h01, 4'h0, 2'h1, 2'h2, 2'b00};
        #1;
        rs(16'hd228, st(0, 0, 0, 0, 4'h0));
        $display("t_fields done");
    endtask

    task automatic t_done;
        wr(16'hd248, 64'h3);
        ev(1, 0, 4'h0);
        rs(16'hd228, st(0, 1, 1, 0, 4'h0));
        chk(64'(done_req), 64'h1);
        ev(0, 1, 4'h0);
        rs(16'hd228, st(0, 1, 1, 1, 4'h0));
        wr(16'hd228, 64'h40);
        rs(16'hd228, st(0, 1, 0, 1, 4'h0));
        wr(16'hd228, 64'h20);
        rs(16'hd228, st(0, 0, 0, 0, 4'h0));
        chk(64'(done_req), 64'h0);
        wr(16'hd248, 64'h1);
        ev(0, 1, 4'h0);
        rs(16'hd228, st(0, 0, 0, 1, 4'h0));
        wr(16'hd228, 64'h20);
        $display("t_done done");
    endtask

    task automatic t_err;
        wr(16'hd248, 64'h4);
        for (int i = 0; i < 4; i++) begin
            ev(0, 0, 4'(1 << i));
            rs(16'hd228, st(1, 0, 0, 0, 4'(1 << i)));
            chk(64'(err_req), 64'h1);
            wr(16'hd228, 64'(1 << i));
            rs(16'hd228, st(0, 0, 0, 0, 4'h0));
        end
        wr(16'hd248, 64'h0);
        ev(0, 0, 4'h5);
        rs(16'hd228, st(0, 0, 0, 0, 4'h5));
        wr(16'hd228, 64'hf);
        $display("t_err done");
    endtask

    task automatic t_irq;
        wr(16'hd238, 64'hf);
        wr(16'hd240, 64'hf);
        rs(16'hd240, 64'hf);
        ev(1, 0, 4'h0);
        rs(16'hd230, 64'h1);
        chk(64'(irq), 64'h1);
        wr(16'hd238, 64'h1);
        rs(16'hd230, 64'h0);
        chk(64'(irq), 64'h0);
        rs(16'h0100, 64'h0);
        rs(16'hd230, 64'h8);
        wr(16'hd238, 64'h8);
        wr(16'hd240, 64'h0);
        ev(0, 1, 4'h0);
        rs(16'hd230, 64'h2);
        chk(64'(irq), 64'h0);
        $display("t_irq done");
    endtask

    task automatic t_rst_mid;
        ev(1, 1, 4'hf);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rs(16'hd228, st(0, 0, 0, 0, 4'h0));
        rs(16'hd230, 64'h0);
        chk(64'({err_req, done_req, irq}), 64'h0);
        $display("t_rst_mid done");
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset;
        t_fields;
        t_done;
        t_err;
        t_irq;
        t_rst_mid;
        end_sim;
    end
endmodule // pci_dma_status_upper_tb
